// *** inc/slc_pkg.sv ***
`default_nettype none
package slc_pkg;
  // ---------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------
  localparam logic [7:0] OFS_WORKING_REG_0  = 8'h00;
  localparam logic [7:0] OFS_WORKING_REG_1  = 8'h02;
  localparam logic [7:0] OFS_WORKING_REG_2  = 8'h04;
  localparam logic [7:0] OFS_WORKING_REG_3  = 8'h06;
  localparam logic [7:0] OFS_WORKING_REG_4  = 8'h08;
  localparam logic [7:0] OFS_WORKING_REG_5  = 8'h0A;
  localparam logic [7:0] OFS_WORKING_REG_6  = 8'h0C;
  localparam logic [7:0] OFS_WORKING_REG_7  = 8'h0E;
  localparam logic [7:0] OFS_WORKING_REG_8  = 8'h10;
  localparam logic [7:0] OFS_WORKING_REG_9  = 8'h12;
  localparam logic [7:0] OFS_WORKING_REG_10 = 8'h14;
  localparam logic [7:0] OFS_WORKING_REG_11 = 8'h16;
  localparam logic [7:0] OFS_WORKING_REG_12 = 8'h18;
  localparam logic [7:0] OFS_WORKING_REG_13 = 8'h1A;
  localparam logic [7:0] OFS_WORKING_REG_14 = 8'h1C;
  localparam logic [7:0] OFS_STACK_POINTER  = 8'h1E;
  localparam logic [7:0] OFS_STACK_LIMIT    = 8'h20;
  localparam logic [7:0] OFS_ACCUM_A_LOW    = 8'h22;
  localparam logic [7:0] OFS_ACCUM_A_HIGH   = 8'h24;
  localparam logic [7:0] OFS_ACCUM_A_UPPER  = 8'h26;
  localparam logic [7:0] OFS_ACCUM_B_LOW    = 8'h28;
  localparam logic [7:0] OFS_STACK_STATUS   = 8'h80;

  // ---------------------------------------------------------
  // storage slots, fields, reset values, limits
  // ---------------------------------------------------------
  localparam int         SLC_NSLOT     = 21;
  localparam logic [4:0] SLOT_SP       = 5'h0F;
  localparam logic [4:0] SLOT_LIM      = 5'h10;
  localparam logic [4:0] SLOT_LAST     = 5'h14;
  localparam int         STAT_OVF_BIT  = 0;
  localparam int         STAT_UDF_BIT  = 1;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [15:0] RST_SP       = 16'h0800;
  localparam logic [15:0] RST_LIMIT    = 16'h0000;
  localparam logic [15:0] STACK_FLOOR  = 16'h0800;
  localparam logic [15:0] STACK_STEP   = 16'h0002;

  // ---------------------------------------------------------
  // bus handshake states
  // ---------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } slc_bus_st_type;
endpackage
`default_nettype wire

// *** inc/slc_chk_if.sv ***
`default_nettype none
interface slc_chk_if;
  logic        chk;
  logic [15:0] ea;
  logic [15:0] limit;
  logic        ovf;
  logic        udf;
  modport regs (output chk, output ea, output limit, input ovf, input udf);
  modport cmp  (input chk, input ea, input limit, output ovf, output udf);
endinterface
`default_nettype wire

// *** src/slc_limit_check.sv ***
`default_nettype none
module slc_limit_check
  import slc_pkg::*;
(
  slc_chk_if.cmp chk_if
);
  // ---------------------------------------------------------
  // address compare
  // ---------------------------------------------------------
  // equal to the limit is still legal, one word beyond traps
  assign chk_if.ovf = chk_if.chk && (chk_if.ea > chk_if.limit);
  // floor guards the special register region
  assign chk_if.udf = chk_if.chk && (chk_if.ea < STACK_FLOOR);
endmodule
`default_nettype wire

// *** src/slc_core_regs.sv ***
`default_nettype none
module slc_core_regs
  import slc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output var  logic [31:0]       o_prdata,
  output var  logic              o_pready,
  output var  logic              o_pslverr,
  input  wire logic              i_push,
  input  wire logic              i_pop,
  input  wire logic              i_ea_chk,
  input  wire logic [15:0]       i_ea_addr,
  output var  logic              o_stack_err,
  output var  logic              o_stack_ovf,
  output var  logic              o_stack_udf,
  output var  logic [15:0]       o_stack_ea,
  output var  logic [15:0]       o_sp
);

  // ---------------------------------------------------------
  // state
  // ---------------------------------------------------------
  typedef struct packed {
    slc_bus_st_type              st;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
    logic [SLC_NSLOT-1:0][15:0]  regs;
    logic [1:0]                  sticky;
    logic                        err;
    logic                        ovf;
    logic                        udf;
    logic [15:0]                 ea;
  } slc_state_type;

  slc_state_type r_reg;
  slc_state_type r_next;

  slc_chk_if chk_if ();

  logic [7:0]  idx;
  logic [4:0]  slot;
  logic        addr_ok;
  logic        in_map;
  logic        is_stat;
  logic [15:0] rd_word;
  logic        wr_now;
  logic        sp_wr;
  logic        lim_wr;
  logic [15:0] sp_cur;
  logic [15:0] wdata;

  // ---------------------------------------------------------
  // address decode
  // ---------------------------------------------------------
  assign idx     = i_paddr[9:2];
  assign slot    = idx[5:1];
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[ADDR_W-1:10] == '0);
  assign in_map  = addr_ok && !idx[0] && (idx <= OFS_ACCUM_B_LOW);
  assign is_stat = addr_ok && (idx == OFS_STACK_STATUS);
  assign wdata   = i_pwdata[15:0];
  assign sp_cur  = r_reg.regs[SLOT_SP];

  // write takes effect at the edge where pready is sampled high
  assign wr_now = (r_reg.st == ST_RESP) && i_psel && i_penable && i_pwrite;
  assign sp_wr  = wr_now && in_map && (slot == SLOT_SP);
  assign lim_wr = wr_now && in_map && (slot == SLOT_LIM);

  always_comb begin
    rd_word = 16'h0000;
    if (in_map) begin
      rd_word = r_reg.regs[slot];
    end else if (is_stat) begin
      rd_word = {14'h0000, r_reg.sticky};
    end
  end

  // ---------------------------------------------------------
  // effective address to the comparator
  // ---------------------------------------------------------
  // push uses the free word, pop the word below it
  assign chk_if.chk   = i_push || i_pop || i_ea_chk;
  assign chk_if.ea    = i_push ? sp_cur :
                        i_pop  ? 16'(sp_cur - STACK_STEP) :
                                 {i_ea_addr[15:1], 1'b0};
  // limit is used as held now; a same-cycle write lands next cycle
  assign chk_if.limit = r_reg.regs[SLOT_LIM];

  slc_limit_check u_limit_check (
    .chk_if (chk_if.cmp)
  );

  // ---------------------------------------------------------
  // next state
  // ---------------------------------------------------------
  always_comb begin
    r_next         = r_reg;
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;
    r_next.err     = chk_if.ovf || chk_if.udf;
    r_next.ovf     = chk_if.ovf;
    r_next.udf     = chk_if.udf;
    if (chk_if.chk) begin
      r_next.ea = chk_if.ea;
    end

    // stack pointer steps; the trap does not stop the step
    if (i_push) begin
      r_next.regs[SLOT_SP] = 16'(sp_cur + STACK_STEP);
    end else if (i_pop) begin
      r_next.regs[SLOT_SP] = 16'(sp_cur - STACK_STEP);
    end

    // bus handshake: one wait cycle, then answer
    case (r_reg.st)
      ST_IDLE: begin
        if (i_psel && i_penable) begin
          r_next.st      = ST_RESP;
          r_next.pready  = 1'b1;
          r_next.pslverr = !(in_map || is_stat);
          r_next.prdata  = {16'h0000, rd_word};
        end
      end
      ST_RESP: begin
        r_next.st = ST_IDLE;
        if (wr_now && in_map) begin
          r_next.regs[slot] = wdata;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase

    // bus write to the pointer overrides a same-cycle step
    if (sp_wr) begin
      r_next.regs[SLOT_SP] = {wdata[15:1], 1'b0};
    end
    if (lim_wr) begin
      r_next.regs[SLOT_LIM] = {wdata[15:1], 1'b0};
    end

    // write-one-to-clear first, so a new event still sets
    if (wr_now && is_stat) begin
      r_next.sticky = r_reg.sticky & ~wdata[1:0];
    end
    if (chk_if.ovf) begin
      r_next.sticky[STAT_OVF_BIT] = 1'b1;
    end
    if (chk_if.udf) begin
      r_next.sticky[STAT_UDF_BIT] = 1'b1;
    end
  end

  // ---------------------------------------------------------
  // registers
  // ---------------------------------------------------------
  // limit resets to a known zero; software must still load it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_reg                <= '0;
      r_reg.st             <= ST_IDLE;
      r_reg.regs[SLOT_SP]  <= RST_SP;
      r_reg.regs[SLOT_LIM] <= RST_LIMIT;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------
  // outputs
  // ---------------------------------------------------------
  assign o_prdata    = r_reg.prdata;
  assign o_pready    = r_reg.pready;
  assign o_pslverr   = r_reg.pslverr;
  assign o_stack_err = r_reg.err;
  assign o_stack_ovf = r_reg.ovf;
  assign o_stack_udf = r_reg.udf;
  assign o_stack_ea  = r_reg.ea;
  assign o_sp        = sp_cur;

  // ---------------------------------------------------------
  // checks
  // ---------------------------------------------------------
  property p_align;
    @(posedge i_clk) disable iff (!i_rstn)
    !r_reg.regs[SLOT_LIM][0] && !o_sp[0];
  endproperty
  a_align: assert property (p_align)
    else $error("stack limit or pointer bit zero set");

  property p_ea_follow;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_ea_chk && !i_push && !i_pop) |=>
      (o_stack_ea == ($past(i_ea_addr) & 16'hFFFE)) &&
      (o_stack_ovf == (o_stack_ea > $past(r_reg.regs[SLOT_LIM]))) &&
      (o_stack_udf == (o_stack_ea < STACK_FLOOR));
  endproperty
  a_ea_follow: assert property (p_ea_follow)
    else $error("checked address not compared with limit");

  property p_push_at_limit;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_push && o_sp == r_reg.regs[SLOT_LIM] && o_sp >= STACK_FLOOR) |=> !o_stack_err;
  endproperty
  a_push_at_limit: assert property (p_push_at_limit)
    else $error("push at limit raised a trap");

  property p_push_beyond;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_push && o_sp > r_reg.regs[SLOT_LIM]) |=>
      (o_stack_err && o_stack_ovf) ##1 (!o_stack_err || $past(chk_if.chk));
  endproperty
  a_push_beyond: assert property (p_push_beyond)
    else $error("push beyond limit did not trap");

  property p_floor;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_pop && o_sp < 16'h0802) |=> o_stack_err && o_stack_udf;
  endproperty
  a_floor: assert property (p_floor)
    else $error("pop below floor did not trap");

  property p_limit_reset;
    @(posedge i_clk)
    $rose(i_rstn) |-> (r_reg.regs[SLOT_LIM] == 16'h0000);
  endproperty
  a_limit_reset: assert property (p_limit_reset)
    else $error("stack limit not known after reset");

  property p_push_step;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_push && !sp_wr) |=> (o_sp == 16'($past(o_sp) + 16'h0002)) &&
                           (o_stack_ea == $past(o_sp));
  endproperty
  a_push_step: assert property (p_push_step)
    else $error("push did not post-increment");

  property p_pop_step;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_pop && !i_push && !sp_wr) |=> (o_sp == o_stack_ea) &&
                                     (o_sp == 16'($past(o_sp) - 16'h0002));
  endproperty
  a_pop_step: assert property (p_pop_step)
    else $error("pop did not pre-decrement");

  property p_sp_reset;
    @(posedge i_clk)
    $rose(i_rstn) |-> (o_sp == 16'h0800) && (r_reg.regs[0] == 16'h0000) && !o_stack_err;
  endproperty
  a_sp_reset: assert property (p_sp_reset)
    else $error("reset values wrong");

  property p_bus_answer;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after access");

  property p_err_source;
    @(posedge i_clk) disable iff (!i_rstn)
    !chk_if.chk |=> !o_stack_err && !o_stack_ovf && !o_stack_udf;
  endproperty
  a_err_source: assert property (p_err_source)
    else $error("stack trap without a checked address");

  property p_ea_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    !chk_if.chk |=> $stable(o_stack_ea);
  endproperty
  a_ea_hold: assert property (p_ea_hold)
    else $error("checked address moved without a check");

  property p_in_range;
    @(posedge i_clk) disable iff (!i_rstn)
    (chk_if.chk && chk_if.ea <= chk_if.limit && chk_if.ea >= STACK_FLOOR) |=> !o_stack_err;
  endproperty
  a_in_range: assert property (p_in_range)
    else $error("address inside bounds raised a trap");

  property p_ovf_sticky;
    @(posedge i_clk) disable iff (!i_rstn)
    chk_if.ovf |=> r_reg.sticky[STAT_OVF_BIT];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow not recorded in status");

  property p_udf_sticky;
    @(posedge i_clk) disable iff (!i_rstn)
    chk_if.udf |=> r_reg.sticky[STAT_UDF_BIT];
  endproperty
  a_udf_sticky: assert property (p_udf_sticky)
    else $error("underflow not recorded in status");

  property p_lim_write;
    @(posedge i_clk) disable iff (!i_rstn)
    lim_wr |=> (r_reg.regs[SLOT_LIM] == 16'($past(i_pwdata) & 32'h0000_FFFE));
  endproperty
  a_lim_write: assert property (p_lim_write)
    else $error("stack limit write not taken");

  property p_sp_write;
    @(posedge i_clk) disable iff (!i_rstn)
    sp_wr |=> (o_sp == 16'($past(i_pwdata) & 32'h0000_FFFE));
  endproperty
  a_sp_write: assert property (p_sp_write)
    else $error("stack pointer write not taken");

  property p_lim_read;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_psel && i_penable && !o_pready && !i_pwrite && in_map && slot == SLOT_LIM) |=>
      !o_prdata[0] && (o_prdata[15:0] == $past(chk_if.limit));
  endproperty
  a_lim_read: assert property (p_lim_read)
    else $error("stack limit read back wrong");

  property p_hole;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_psel && i_penable && !o_pready && !in_map && !is_stat) |=> o_pslverr && (o_prdata == 32'h0000_0000);
  endproperty
  a_hole: assert property (p_hole)
    else $error("unmapped access not refused");

  property p_rd_upper;
    @(posedge i_clk) disable iff (!i_rstn)
    o_pready |-> (o_prdata[31:16] == 16'h0000);
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read data upper half not zero");

endmodule
`default_nettype wire

// *** verif/tb_stack_limit_check_core_regs.sv ***
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_stack_limit_check_core_regs
  import slc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // stimulus and observed signals
  // ----------
  logic        clk        = 1'b0;
  logic        rstn       = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [15:0] paddr      = 16'h0000;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic        push       = 1'b0;
  logic        pop        = 1'b0;
  logic        ea_chk     = 1'b0;
  logic [15:0] ea_addr    = 16'h0000;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_stack_err;
  logic        o_stack_ovf;
  logic        o_stack_udf;
  logic [15:0] o_stack_ea;
  logic [15:0] o_sp;
  int          fails      = 0;
  int          n_compared = 0;

  always #2.5 clk = ~clk;

  slc_core_regs #(.ADDR_W(16)) DUT (
    .i_clk      (clk),
    .i_rstn     (rstn),
    .i_psel     (psel),
    .i_penable  (penable),
    .i_pwrite   (pwrite),
    .i_paddr    (paddr),
    .i_pwdata   (pwdata),
    .o_prdata   (o_prdata),
    .o_pready   (o_pready),
    .o_pslverr  (o_pslverr),
    .i_push     (push),
    .i_pop      (pop),
    .i_ea_chk   (ea_chk),
    .i_ea_addr  (ea_addr),
    .o_stack_err(o_stack_err),
    .o_stack_ovf(o_stack_ovf),
    .o_stack_udf(o_stack_udf),
    .o_stack_ea (o_stack_ea),
    .o_sp       (o_sp)
  );

  // ----------
  // bus tasks
  // ----------
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {6'h00, idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    // wait state count is the slave's business, bounded here
    do begin
      @(posedge clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (o_pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
    rd = o_prdata;
    er = o_pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, idx, d, rd, er);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [15:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, idx, 16'h0000, rd, er);
    `CHK(nm, {16'h0000, e}, rd)
    `CHK("slverr", 1'b0, er)
  endtask

  task automatic probe(input logic [15:0] a, input logic ov, input logic ud);
    @(posedge clk);
    ea_chk  <= 1'b1;
    ea_addr <= a;
    @(posedge clk);
    ea_chk  <= 1'b0;
    #1;
    `CHK("o_stack_ea", a, o_stack_ea)
    `CHK("o_stack_ovf", ov, o_stack_ovf)
    `CHK("o_stack_udf", ud, o_stack_udf)
    `CHK("o_stack_err", ov | ud, o_stack_err)
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_reset();
    for (int i = 0; i <= 8'h28; i += 2) begin
      rdchk("reset word", 8'(i), (8'(i) == OFS_STACK_POINTER) ? RST_SP : RST_WORD);
    end
    rdchk("limit reset", OFS_STACK_LIMIT, RST_LIMIT);
    `CHK("o_sp", 16'h0800, o_sp)
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic        er;
    for (int i = 0; i <= 8'h28; i += 2) begin
      if (i == 8'h1E || i == 8'h20) continue;
      wr(8'(i), 16'h5A00 | 16'(i));
      rdchk("word rw", 8'(i), 16'h5A00 | 16'(i));
    end
    wr(OFS_STACK_LIMIT, 16'h1235);
    rdchk("limit bit0", OFS_STACK_LIMIT, 16'h1234);
    wr(OFS_STACK_POINTER, 16'h0901);
    rdchk("sp bit0", OFS_STACK_POINTER, 16'h0900);
    // index just past the last word and odd index are holes in the map
    apb(1'b1, 8'h2A, 16'hFFFF, rd, er);
    `CHK("slverr wr", 1'b1, er)
    apb(1'b0, 8'h81, 16'h0000, rd, er);
    `CHK("slverr rd", 1'b1, er)
    `CHK("hole data", 32'h0000_0000, rd)
    $display("test regs done");
  endtask

  task automatic t_ovf();
    wr(OFS_STACK_LIMIT, 16'h1FFE);
    // spare bus cycle keeps limit write apart from stack use
    wr(OFS_STACK_POINTER, 16'h1FFE);
    @(posedge clk);
    push <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("sp push1", 16'h2000, o_sp)
    `CHK("ea push1", 16'h1FFE, o_stack_ea)
    `CHK("err push1", 1'b0, o_stack_err)
    @(posedge clk);
    push <= 1'b0;
    #1;
    `CHK("sp push2", 16'h2002, o_sp)
    `CHK("ea push2", 16'h2000, o_stack_ea)
    `CHK("err push2", 1'b1, o_stack_err)
    `CHK("ovf push2", 1'b1, o_stack_ovf)
    @(posedge clk);
    #1;
    `CHK("err pulse", 1'b0, o_stack_err)
    rdchk("status ovf", OFS_STACK_STATUS, 16'h0001);
    wr(OFS_STACK_STATUS, 16'h0003);
    rdchk("status clr", OFS_STACK_STATUS, 16'h0000);
    probe(16'h1FFE, 1'b0, 1'b0);
    probe(16'h2002, 1'b1, 1'b0);
    probe(16'h1000, 1'b0, 1'b0);
    $display("test overflow done");
  endtask

  task automatic t_udf();
    wr(OFS_STACK_POINTER, 16'h0802);
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("sp pop1", 16'h0800, o_sp)
    `CHK("err pop1", 1'b0, o_stack_err)
    @(posedge clk);
    pop <= 1'b0;
    #1;
    `CHK("sp pop2", 16'h07FE, o_sp)
    `CHK("ea pop2", 16'h07FE, o_stack_ea)
    `CHK("udf pop2", 1'b1, o_stack_udf)
    `CHK("err pop2", 1'b1, o_stack_err)
    probe(16'h0800, 1'b0, 1'b0);
    probe(16'h07FE, 1'b0, 1'b1);
    rdchk("status udf", OFS_STACK_STATUS, 16'h0003);
    $display("test underflow done");
  endtask

  // second reset with nonzero state, then the reset map again
  task automatic t_mid_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("sp in reset", RST_SP, o_sp)
    `CHK("ea in reset", 16'h0000, o_stack_ea)
    `CHK("err in reset", 1'b0, o_stack_err)
    rstn <= 1'b1;
    t_reset();
  endtask

  // ----------
  // run control
  // ----------
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_ovf();
    t_udf();
    t_mid_reset();
    wrap_up();
  end

  // whole run is a few hundred cycles, so this margin is generous
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule
`default_nettype wire
